//--- logic/dfr_manager.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// - Power hardware monitor fault gives error 12
// - Input phase loss via DC ripple: 3
// - No auto restart after input phase failure
// - Phase check enable: 0 off, 1 on
// - Check needs enable, type<=2, f>4Hz, load>7%
// - Trip output phase fault after 250 ms
// - Acceleration from speed change over window
// - Excess acceleration gives code 24 or 106
// - Eleven sources have selectable non-forcing responses
// - Overload/heat errors switch modulation off if their source is enabled
// - Motor protection and temperature individually disableable
// - Code 0: error, off now, reset
// - Code 1: stop ramp, off, reset
// - Code 2: stop ramp, hold torque, reset
// - Code 3: off now, auto restart
// - Code 4: stop, off, auto restart
// - Code 5: stop, hold torque, auto restart
// - Code 6: digital output warning only
// - Limit switch and set responses switchable off
// - Code 6 ignores limit switch, set faults
// - Internal overtemperature error at 100 C always
module dfr_manager #(
  parameter int TICK_CYCLES = dfr_pkg::TICK_CYCLES_DEF
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire logic power_hw_fault,
  input wire logic dc_ripple_high,
  input wire logic output_phase_open,
  input wire logic [15:0] output_frequency_value,
  input wire logic [7:0] load_utilization_value,
  input wire logic signed [15:0] actual_speed_value,
  input wire logic [7:0] internal_temp_c,
  input wire logic zero_speed,
  input wire logic [10:0] fault_in,
  input wire logic [4:0] hard_error_in,
  input wire logic fault_reset,
  output dfr_pkg::dfr_drive_t drive
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] acc_limit;
    logic [15:0] acc_window;
    logic [43:0] resp;
    logic [10:0] latched;
    logic [10:0] warn;
    logic hw_err;
    logic phase_err;
    logic outp_err;
    logic [4:0] prew_err;
    logic ohi_err;
    logic [15:0] tick_cnt;
    logic [15:0] win_cnt;
    logic signed [15:0] speed_start;
    logic accel_exceed;
    logic [9:0] outp_cnt;
    logic [31:0] rdata;
    dfr_pkg::dfr_drive_t drive;
  } dfr_state_t;

  dfr_state_t st;
  dfr_state_t next_st;

  logic [3:0] code;
  logic tick;
  logic outp_cond;
  logic [10:0] src_fault;
  logic [10:0] src_enable;
  logic hard_any;
  logic off_now;
  logic stop_off;
  logic stop_hold;
  logic [16:0] speed_diff;
  logic [16:0] speed_abs;
  logic [39:0] acc_lhs;
  logic [39:0] acc_rhs;
  logic [15:0] win_len;
  logic [7:0] status_code;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    code = 4'h0;
    tick = (st.tick_cnt == 16'(TICK_CYCLES - 1));
    outp_cond = 1'b0;
    src_fault = 11'h0;
    src_enable = 11'h0;
    hard_any = 1'b0;
    off_now = 1'b0;
    stop_off = 1'b0;
    stop_hold = 1'b0;
    status_code = dfr_pkg::CODE_NONE;
    win_len = (st.acc_window == 16'h0) ? 16'h0001 : st.acc_window;
    speed_diff = 17'(actual_speed_value) - 17'(st.speed_start);
    speed_abs = speed_diff[16] ? 17'(-speed_diff) : speed_diff;

    // Register writes
    if (reg_write) begin
      case (reg_addr)
        dfr_pkg::ADDR_CTRL: next_st.ctrl = reg_wdata[15:0];
        dfr_pkg::ADDR_ACC_LIMIT: next_st.acc_limit = reg_wdata[15:0];
        dfr_pkg::ADDR_ACC_WINDOW: next_st.acc_window = reg_wdata[15:0];
        dfr_pkg::ADDR_RESP_LO: next_st.resp[31:0] = reg_wdata;
        dfr_pkg::ADDR_RESP_HI: next_st.resp[43:32] = reg_wdata[11:0];
        default: next_st.ctrl = st.ctrl;
      endcase
    end

    // Millisecond time base
    next_st.tick_cnt = tick ? 16'h0 : st.tick_cnt + 16'h1;

    // Acceleration over the averaging window in 1/s^2
    acc_lhs = 40'(speed_abs) * 40'd1000;
    acc_rhs = 40'(st.acc_limit) * 40'd60 * 40'(win_len);
    if (tick) begin
      if (st.win_cnt + 16'h1 >= win_len) begin
        next_st.win_cnt = 16'h0;
        next_st.speed_start = actual_speed_value;
        next_st.accel_exceed = (acc_lhs > acc_rhs);
      end else begin
        next_st.win_cnt = st.win_cnt + 16'h1;
      end
    end

    // Output phase loss supervision
    outp_cond = st.ctrl[0]
      && (st.ctrl[10:8] <= 3'h2) && (output_frequency_value > dfr_pkg::FREQ_MIN)
      && (load_utilization_value > dfr_pkg::LOAD_MIN);
    if (!(outp_cond && output_phase_open)) begin
      next_st.outp_cnt = 10'h0;
    end else if (tick && (st.outp_cnt != dfr_pkg::OUT_PHASE_TRIP_TICKS)) begin
      next_st.outp_cnt = st.outp_cnt + 10'h1;
    end

    // Fault sources, acceleration taken from own monitor
    src_fault = fault_in;
    src_fault[dfr_pkg::SRC_ACCEL] = st.accel_exceed;
    src_enable = 11'h7FF;
    src_enable[dfr_pkg::SRC_MOTOR_TEMP] = st.ctrl[4];
    src_enable[dfr_pkg::SRC_MOTOR_PROT] = st.ctrl[5];

    // Hard errors clear on reset once cause is gone; set wins
    if (fault_reset) begin
      if (!power_hw_fault) next_st.hw_err = 1'b0;
      if (!dc_ripple_high) next_st.phase_err = 1'b0;
      if (!(outp_cond && output_phase_open)) next_st.outp_err = 1'b0;
      if (internal_temp_c < dfr_pkg::INT_TEMP_TRIP) next_st.ohi_err = 1'b0;
    end
    if (power_hw_fault) next_st.hw_err = 1'b1;
    if (dc_ripple_high) next_st.phase_err = 1'b1;
    if (st.outp_cnt == dfr_pkg::OUT_PHASE_TRIP_TICKS) next_st.outp_err = 1'b1;
    if (internal_temp_c >= dfr_pkg::INT_TEMP_TRIP) next_st.ohi_err = 1'b1;

    // Enabled pre-warning sources end in an error that forces modulation off
    for (int j = 0; j < 5; j++) begin
      if (fault_reset && !hard_error_in[j]) next_st.prew_err[j] = 1'b0;
      if (hard_error_in[j] && src_enable[dfr_pkg::SRC_OVERLOAD + j]) begin
        next_st.prew_err[j] = 1'b1;
      end
    end

    // Per-source response latch
    for (int i = 0; i < dfr_pkg::NSRC; i++) begin
      code = st.resp[4*i +: 4];
      next_st.warn[i] = 1'b0;
      if (st.latched[i] && !src_fault[i]) begin
        if (dfr_pkg::resp_retry(code) || fault_reset) begin
          next_st.latched[i] = 1'b0;
        end
      end
      if (src_fault[i] && src_enable[i]) begin
        if (code <= 4'h5) begin
          next_st.latched[i] = 1'b1;
        end else if (code == 4'h6 && i != dfr_pkg::SRC_LIMIT && i != dfr_pkg::SRC_SET) begin
          next_st.warn[i] = 1'b1;
        end
      end
      // Codes above 6, and 6 on limit and set, ignore the fault
    end

    // Combine latched responses into drive commands
    hard_any = st.hw_err || st.phase_err || st.outp_err || st.ohi_err || (st.prew_err != 5'h0);
    for (int i = dfr_pkg::NSRC - 1; i >= 0; i--) begin
      code = st.resp[4*i +: 4];
      if (st.latched[i]) begin
        if (dfr_pkg::resp_off_now(code)) begin
          off_now = 1'b1;
          status_code = dfr_pkg::ERR_CODE[i];
        end else if (dfr_pkg::resp_stop(code)) begin
          status_code = dfr_pkg::ABN_CODE[i];
          if (code == 4'h2 || code == 4'h5) begin
            stop_hold = 1'b1;
          end else begin
            stop_off = 1'b1;
          end
        end
      end
    end
    for (int j = 4; j >= 0; j--) begin
      if (st.prew_err[j]) status_code = dfr_pkg::ERR_CODE[dfr_pkg::SRC_OVERLOAD + j];
    end
    if (st.ohi_err) status_code = dfr_pkg::CODE_INT_OVERTEMP;
    if (st.outp_err) status_code = dfr_pkg::CODE_OUT_PHASE;
    if (st.phase_err) status_code = dfr_pkg::CODE_PHASE_FAIL;
    if (st.hw_err) status_code = dfr_pkg::CODE_POWER_UNIT;

    // Drive outputs
    next_st.drive.error_active = hard_any || off_now;
    next_st.drive.quick_stop = !(hard_any || off_now) && (stop_off || stop_hold);
    next_st.drive.hold_torque = !(hard_any || off_now) && !stop_off && stop_hold && zero_speed;
    next_st.drive.modulation_on = !(hard_any || off_now) && !(stop_off && zero_speed);
    next_st.drive.digital_warning = (st.warn != 11'h0);
    next_st.drive.state_code = status_code;

    // Register reads, data valid one cycle later
    next_st.rdata = 32'h0;
    if (reg_read) begin
      case (reg_addr)
        dfr_pkg::ADDR_CTRL: next_st.rdata = {16'h0, st.ctrl};
        dfr_pkg::ADDR_ACC_LIMIT: next_st.rdata = {16'h0, st.acc_limit};
        dfr_pkg::ADDR_ACC_WINDOW: next_st.rdata = {16'h0, st.acc_window};
        dfr_pkg::ADDR_RESP_LO: next_st.rdata = st.resp[31:0];
        dfr_pkg::ADDR_RESP_HI: next_st.rdata = {20'h0, st.resp[43:32]};
        dfr_pkg::ADDR_STATUS: next_st.rdata = {10'h0, st.accel_exceed, st.ohi_err, st.prew_err,
                                               st.outp_err, st.phase_err, st.hw_err,
                                               st.drive.modulation_on, st.drive.quick_stop,
                                               st.drive.hold_torque, st.drive.error_active,
                                               st.drive.state_code};
        dfr_pkg::ADDR_ACTIVE: next_st.rdata = {5'h0, st.warn, st.latched};
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      st <= '0;
      st.ctrl <= dfr_pkg::CTRL_RESET;
      st.acc_limit <= dfr_pkg::ACC_LIMIT_RESET;
      st.acc_window <= dfr_pkg::ACC_WINDOW_RESET;
      st.resp <= dfr_pkg::RESP_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st.rdata;
  assign drive = st.drive;

endmodule
`default_nettype wire

//--- logic/dfr_pkg.sv
package dfr_pkg;

  // ----------------------------------------------------------------
  // Register map and sizes
  // ----------------------------------------------------------------
  localparam int NSRC = 11;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ACC_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_ACC_WINDOW = 8'h08;
  localparam logic [7:0] ADDR_RESP_LO = 8'h0C;
  localparam logic [7:0] ADDR_RESP_HI = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_ACTIVE = 8'h18;
  localparam logic [15:0] CTRL_RESET = 16'h0030;
  localparam logic [15:0] ACC_LIMIT_RESET = 16'hFFFF;
  localparam logic [15:0] ACC_WINDOW_RESET = 16'h000A;
  localparam logic [43:0] RESP_RESET = 44'h0;

  // Source indices
  localparam int SRC_EXT = 0;
  localparam int SRC_WDOG = 1;
  localparam int SRC_LIMIT = 2;
  localparam int SRC_SET = 3;
  localparam int SRC_SPEED = 4;
  localparam int SRC_ACCEL = 5;
  localparam int SRC_OVERLOAD = 6;
  localparam int SRC_MOTOR_TEMP = 9;
  localparam int SRC_MOTOR_PROT = 10;

  // ----------------------------------------------------------------
  // State codes and thresholds
  // ----------------------------------------------------------------
  localparam logic [7:0] CODE_NONE = 8'h00;
  localparam logic [7:0] CODE_PHASE_FAIL = 8'h03;
  localparam logic [7:0] CODE_POWER_UNIT = 8'h0C;
  localparam logic [7:0] CODE_OUT_PHASE = 8'h0D;
  localparam logic [7:0] CODE_INT_OVERTEMP = 8'h08;
  localparam logic [7:0] ERR_CODE [NSRC] = '{8'h1F, 8'h12, 8'h1A, 8'h27, 8'h19, 8'h18,
                                            8'h10, 8'h08, 8'h08, 8'h09, 8'h1E};
  localparam logic [7:0] ABN_CODE [NSRC] = '{8'h64, 8'h5D, 8'h65, 8'h66, 8'h67, 8'h6A,
                                            8'h61, 8'h62, 8'h63, 8'h60, 8'h68};
  localparam logic [15:0] FREQ_MIN = 16'h0028; // 4 Hz in 0.1 Hz units
  localparam logic [7:0] LOAD_MIN = 8'h07;
  localparam logic [7:0] INT_TEMP_TRIP = 8'h64;
  localparam int CLK_HZ = 40000000;
  localparam int OUT_PHASE_TRIP_MS = 250;
  localparam logic [9:0] OUT_PHASE_TRIP_TICKS = 10'(OUT_PHASE_TRIP_MS);
  localparam int TICK_CYCLES_DEF = CLK_HZ / 1000;

  // ----------------------------------------------------------------
  // Response decoding
  // ----------------------------------------------------------------
  function automatic logic resp_off_now(input logic [3:0] c);
    return (c == 4'h0) || (c == 4'h3);
  endfunction

  function automatic logic resp_stop(input logic [3:0] c);
    return (c == 4'h1) || (c == 4'h2) || (c == 4'h4) || (c == 4'h5);
  endfunction

  function automatic logic resp_retry(input logic [3:0] c);
    return (c == 4'h3) || (c == 4'h4) || (c == 4'h5);
  endfunction

  // Drive outputs
  typedef struct packed {
    logic modulation_on;
    logic quick_stop;
    logic hold_torque;
    logic error_active;
    logic digital_warning;
    logic [7:0] state_code;
  } dfr_drive_t;

endpackage

//--- tb/dfr_checker.sv
`timescale 1ns/100ps
`default_nettype none
module dfr_checker (
  input wire logic clock,
  input wire logic rst,
  input wire logic power_hw_fault,
  input wire logic dc_ripple_high,
  input wire logic [7:0] internal_temp_c,
  input wire logic zero_speed,
  input wire logic [4:0] hard_error_in,
  input wire logic fault_reset,
  input wire dfr_pkg::dfr_drive_t drive
);
  // ----------------------------------------------------------------
  // Shutdown and latching checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Modulation off two cycles after its cause
  sequence s_off;
    ##2 !drive.modulation_on;
  endsequence
  // No reset request seen lately
  sequence s_no_rst;
    !fault_reset && !$past(fault_reset);
  endsequence
  AST_POWER_ERR: assert property (
    power_hw_fault |-> s_off ##0 drive.state_code == 8'h0C)
    else $error("power unit fault not reported");
  AST_POWER_HOLD: assert property (
    s_no_rst ##0 drive.state_code == 8'h0C |=> drive.state_code == 8'h0C)
    else $error("power unit error left without reset");
  AST_PHASE_ERR: assert property (
    dc_ripple_high |-> s_off ##0 (drive.state_code inside {8'h03, 8'h0C}))
    else $error("input phase loss not reported");
  AST_PHASE_HOLD: assert property (
    s_no_rst ##0 drive.state_code == 8'h03 |=> (drive.state_code inside {8'h03, 8'h0C}) && !drive.modulation_on)
    else $error("input phase error restarted by itself");
  AST_HARD_OFF: assert property (
    |hard_error_in[2:0] |-> s_off)
    else $error("hard error left modulation on");
  AST_OHI: assert property (
    internal_temp_c >= 8'h64 |-> ##2 drive.error_active && !drive.modulation_on)
    else $error("internal overtemperature not forced");
  AST_ERR_OFF: assert property (
    drive.error_active |-> !drive.modulation_on)
    else $error("error with modulation on");
  AST_HOLD_ON: assert property (
    drive.hold_torque |-> drive.modulation_on && $past(zero_speed))
    else $error("holding torque without modulation at zero speed");
endmodule
`default_nettype wire

//--- tb/dfr_far_model.sv
`timescale 1ns/100ps
`default_nettype none
module dfr_far_model (
  input wire logic clock,
  input wire logic rst,
  input wire dfr_pkg::dfr_drive_t drive,
  input wire logic signed [15:0] target,
  input wire logic [7:0] step,
  output logic signed [15:0] speed,
  output logic zero_speed
);
  logic signed [15:0] goal;
  logic signed [15:0] stp;
  // Motor runs to target only while modulating and not stopping
  assign goal = (drive.modulation_on && !drive.quick_stop) ? target : 16'sh0000;
  assign stp = {8'h00, step};
  assign zero_speed = (speed == 16'sh0000);
  // Speed moves one step a cycle, slow or prompt as step says
  always_ff @(posedge clock) begin
    if (rst) begin
      speed <= 16'sh0000;
    end else if (speed + stp <= goal) begin
      speed <= speed + stp;
    end else if (speed - stp >= goal) begin
      speed <= speed - stp;
    end else begin
      speed <= goal;
    end
  end
endmodule
`default_nettype wire

//--- tb/drive_fault_response_manager_tb.sv
`timescale 1ns/100ps
`default_nettype none
module drive_fault_response_manager_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic reg_write = 1'b0, reg_read = 1'b0, power_hw_fault = 1'b0, dc_ripple_high = 1'b0;
  logic output_phase_open = 1'b0, fault_reset = 1'b0, zero_speed;
  logic [7:0] reg_addr = 8'h00, load = 8'h00, temp = 8'h19, step = 8'h32;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [15:0] freq = 16'h0;
  logic signed [15:0] spd, target = 16'sh03E8;
  logic [10:0] fault_in = 11'h0;
  logic [4:0] hard_error_in = 5'h0;
  dfr_pkg::dfr_drive_t drive;
  int mismatches = 0, checks = 0;
  // ----------------------------------------------------------------
  // Clock, design and far side
  // ----------------------------------------------------------------
  initial begin
    forever #12.5 clock = ~clock;
  end
  dfr_manager #(.TICK_CYCLES(10)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .power_hw_fault(power_hw_fault), .dc_ripple_high(dc_ripple_high),
    .output_phase_open(output_phase_open), .output_frequency_value(freq),
    .load_utilization_value(load), .actual_speed_value(spd), .internal_temp_c(temp),
    .zero_speed(zero_speed), .fault_in(fault_in), .hard_error_in(hard_error_in),
    .fault_reset(fault_reset), .drive(drive));
  dfr_far_model far (.clock(clock), .rst(rst), .drive(drive), .target(target), .step(step),
    .speed(spd), .zero_speed(zero_speed));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic clr;
    @(posedge clock);
    fault_reset <= 1'b1;
    @(posedge clock);
    fault_reset <= 1'b0;
    cyc(5);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(dfr_pkg::ADDR_CTRL, 32'h30);
    rd(dfr_pkg::ADDR_ACC_LIMIT, 32'hFFFF);
    rd(dfr_pkg::ADDR_ACC_WINDOW, 32'hA);
    rd(dfr_pkg::ADDR_RESP_LO, 32'h0);
    rd(dfr_pkg::ADDR_RESP_HI, 32'h0);
    rd(dfr_pkg::ADDR_STATUS, 32'h800);
    rd(dfr_pkg::ADDR_ACTIVE, 32'h0);
    rd(8'h1C, 32'h0);
  endtask
  task automatic t_hw;
    logic [7:0] s;
    for (int i = 0; i < 2; i++) begin
      s = i ? 8'h03 : 8'h0C;
      @(posedge clock);
      power_hw_fault <= (i == 0);
      dc_ripple_high <= (i == 1);
      cyc(5);
      chk("state_code", s, drive.state_code);
      @(posedge clock);
      power_hw_fault <= 1'b0;
      dc_ripple_high <= 1'b0;
      cyc(50);
      chk("state_code", s, drive.state_code);
      clr;
      chk("modulation_on", 1, drive.modulation_on);
    end
  endtask
  task automatic t_resp;
    logic [7:0] s;
    for (int c = 0; c < 7; c++) begin
      s = (c == 6) ? 8'h00 : (c == 0 || c == 3) ? dfr_pkg::ERR_CODE[0] : dfr_pkg::ABN_CODE[0];
      wr(dfr_pkg::ADDR_RESP_LO, c);
      step <= c[0] ? 8'h32 : 8'h05;
      cyc(300);
      @(posedge clock);
      fault_in[0] <= 1'b1;
      cyc(400);
      chk("state_code", s, drive.state_code);
      chk("modulation_on", 7'h64 >> c & 1, drive.modulation_on);
      chk("hold_torque", 7'h24 >> c & 1, drive.hold_torque);
      chk("digital_warning", c == 6, drive.digital_warning);
      @(posedge clock);
      fault_in[0] <= 1'b0;
      cyc(20);
      chk("state_code", c > 2 ? 8'h00 : s, drive.state_code);
      clr;
    end
  endtask
  task automatic t_off;
    wr(dfr_pkg::ADDR_RESP_LO, 32'h7600);
    @(posedge clock);
    fault_in[3:2] <= 2'b11;
    cyc(10);
    chk("state_code", 0, drive.state_code);
    chk("digital_warning", 0, drive.digital_warning);
    @(posedge clock);
    fault_in[3:2] <= 2'b00;
    wr(dfr_pkg::ADDR_RESP_LO, 32'h0);
  endtask
  task automatic t_outp;
    for (int i = 0; i < 3; i++) begin
      wr(dfr_pkg::ADDR_CTRL, i == 1 ? 32'h30 : 32'h31);
      freq <= i == 2 ? 16'h0028 : 16'h0029;
      load <= 8'h08;
      output_phase_open <= 1'b1;
      cyc(2440);
      chk("state_code", 0, drive.state_code);
      cyc(160);
      chk("state_code", i ? 8'h00 : 8'h0D, drive.state_code);
      @(posedge clock);
      output_phase_open <= 1'b0;
      clr;
    end
    wr(dfr_pkg::ADDR_CTRL, 32'h30);
  endtask
  task automatic t_acc;
    wr(dfr_pkg::ADDR_ACC_WINDOW, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(dfr_pkg::ADDR_ACC_LIMIT, i == 2 ? 32'h3E8 : 32'h46);
      wr(dfr_pkg::ADDR_RESP_LO, (i == 1) << 20);
      target <= 16'sh0000;
      cyc(300);
      clr;
      @(posedge clock);
      target <= 16'sh03E8;
      cyc(60);
      chk("state_code", i == 2 ? 8'h00 : i ? 8'h6A : 8'h18, drive.state_code);
    end
    wr(dfr_pkg::ADDR_ACC_LIMIT, 32'hFFFF);
    clr;
  endtask
  task automatic t_hard;
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      hard_error_in <= i ? 5'h00 : 5'h01;
      temp <= i ? 8'h64 : 8'h19;
      cyc(5);
      chk("modulation_on", 0, drive.modulation_on);
      @(posedge clock);
      hard_error_in <= 5'h00;
      temp <= 8'h19;
      clr;
      chk("modulation_on", 1, drive.modulation_on);
    end
  endtask
  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    cyc(5);
    t_regs;
    t_hw;
    t_off;
    t_resp;
    t_outp;
    t_acc;
    t_hard;
    finish_test;
  end
  initial begin
    repeat (60000) @(posedge clock);
    mismatches++;
    finish_test;
  end
endmodule
bind dfr_manager dfr_checker chk_i (.clock(clock), .rst(rst), .power_hw_fault(power_hw_fault),
  .dc_ripple_high(dc_ripple_high), .internal_temp_c(internal_temp_c), .zero_speed(zero_speed),
  .hard_error_in(hard_error_in), .fault_reset(fault_reset), .drive(drive));
`default_nettype wire
